// File: common/ftrb_pkg.sv
// shared constants and types of the motor-control telemetry register bank
// assumes a 32-bit apb slave and a telemetry source on the same clock
package ftrb_pkg;

    // data path widths
    localparam int DATA_W = 32;   // telemetry word width
    localparam int ISD_W  = 16;   // speed-detect state code width
    localparam int ADDR_W = 14;   // byte address width of the bank
    localparam int IDX_W  = 12;   // register index width
    localparam int STRB_W = 4;    // apb byte strobes

    // register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_VOLT_D  = 12'h4e6;
    localparam logic [IDX_W-1:0] IDX_VOLT_Q  = 12'h4e8;
    localparam logic [IDX_W-1:0] IDX_ALIGN   = 12'h524;
    localparam logic [IDX_W-1:0] IDX_OL_SPD  = 12'h53c;
    localparam logic [IDX_W-1:0] IDX_OL_CUR  = 12'h54c;
    localparam logic [IDX_W-1:0] IDX_CL_SPD  = 12'h5d2;
    localparam logic [IDX_W-1:0] IDX_FLUX    = 12'h604;
    localparam logic [IDX_W-1:0] IDX_TORQUE  = 12'h606;
    localparam logic [IDX_W-1:0] IDX_ISD     = 12'h680;
    localparam logic [IDX_W-1:0] IDX_EVT_STS = 12'h7f0;
    localparam logic [IDX_W-1:0] IDX_EVT_MSK = 12'h7f2;

    // fixed-point scaling of the 32-bit telemetry words
    localparam int FRAC_BITS    = 27;  // fractional bits
    localparam int VOLT_NUM     = 60;  // voltage numerator, over sqrt 3
    localparam int CUR_DIV      = 8;   // base current divisor

    // event status and mask layout
    localparam int EVT_W        = 4;
    localparam int EVT_SAMPLE   = 0;   // new telemetry loaded
    localparam int EVT_ISD_CHG  = 1;   // speed-detect state moved
    localparam int EVT_ISD_DONE = 2;   // speed detection finished
    localparam int EVT_ISD_FAIL = 3;   // speed detection faulted

    // reset values
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [ISD_W-1:0]  RST_ISD  = 16'h0000;
    localparam logic [EVT_W-1:0]  RST_EVT  = 4'h0;

    // speed-detect state codes
    typedef enum logic [ISD_W-1:0] {
        speed_detect_initialising    = 16'h0000,
        speed_detect_stop_check      = 16'h0001,
        speed_detect_direction_check = 16'h0002,
        speed_detect_done            = 16'h0003,
        speed_detect_failed          = 16'h0004
    } ftrb_isd_e;

    // one snapshot of the control engine
    typedef struct packed {
        logic [DATA_W-1:0] applied_d_axis_voltage;
        logic [DATA_W-1:0] applied_q_axis_voltage;
        logic [DATA_W-1:0] align_current_reference;
        logic [DATA_W-1:0] open_loop_speed_reference;
        logic [DATA_W-1:0] open_loop_current_reference;
        logic [DATA_W-1:0] closed_loop_speed_reference;
        logic [DATA_W-1:0] flux_current_reference;
        logic [DATA_W-1:0] torque_current_reference;
        logic [ISD_W-1:0]  initial_speed_detect_state;
    } ftrb_telem_s;

    // apb request group
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [STRB_W-1:0] pstrb;
    } ftrb_apb_req_s;

endpackage

// File: logic/ftrb_evt.sv
// sticky event status of the telemetry bank
// assumes load, codes and clear pulses all come from the pclk domain
`timescale 1ns/1ps
module ftrb_evt
    import ftrb_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             load,      // snapshot taken this cycle
    input  wire logic [ISD_W-1:0] old_code,  // code before the load
    input  wire logic [ISD_W-1:0] new_code,  // code being loaded
    input  wire logic [EVT_W-1:0] clr,       // write-one-to-clear pulse
    output logic      [EVT_W-1:0] status     // sticky event bits
);

    logic [EVT_W-1:0] set;     // events found this cycle
    logic             changed; // state code moved

    // decode events from the incoming snapshot
    always_comb begin
        changed = load && (new_code != old_code);
        set = RST_EVT;
        set[EVT_SAMPLE]   = load;
        set[EVT_ISD_CHG]  = changed;
        // only entry into done or fault counts, not staying there
        set[EVT_ISD_DONE] = changed && (new_code == speed_detect_done);
        set[EVT_ISD_FAIL] = changed && (new_code == speed_detect_failed);
    end

    // set beats clear so a coincident event is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= RST_EVT;
        end else begin
            status <= (status & ~clr) | set;
        end
    end

endmodule

// File: logic/ftrb_bank.sv
// apb register bank exposing field-oriented control telemetry
// assumes one 50 MHz clock, telemetry from core logic on that clock,
// and an apb master that follows the usual setup and access phases
//
// Functional notes
// RL1: report applied d-axis voltage, 27 fraction bits
// RL2: report applied q-axis voltage, 27 fraction bits
// RL3: expose align current reference word
// RL4: expose open-loop speed reference word
// RL5: open-loop speed is the hand-over speed
// RL6: expose open-loop current reference word
// RL7: expose closed-loop speed reference word
// RL8: expose flux loop d-axis current reference
// RL9: expose torque loop q-axis current reference
// RL10: report 16-bit speed-detect state code
// RL11: writes ignored; all registers reset to zero; event mask and status accept writes
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module ftrb_bank
    import ftrb_pkg::*;
#(
    parameter int AW = ADDR_W  // byte address width
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [STRB_W-1:0] pstrb,
    input  wire ftrb_telem_s       telem,
    input  wire logic              telem_load,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq
);

    // held copy of the engine quantities
    ftrb_telem_s      shadow;

    // event plumbing
    logic [EVT_W-1:0] evt_status;   // sticky bits
    logic [EVT_W-1:0] evt_mask;     // enables onto irq
    logic [EVT_W-1:0] evt_clr;      // write-one-to-clear
    logic [EVT_W-1:0] next_mask;    // mask after a write

    // bus phase decode
    logic             access;       // first access cycle
    logic             fire;         // completing edge
    logic             wr_fire;      // completing write
    logic [IDX_W-1:0] idx;          // word index of paddr
    logic             aligned;      // low address bits zero
    logic             hit;          // mapped register
    logic [DATA_W-1:0] rd_val;      // value to return

    // word index from a byte address
    function automatic logic [IDX_W-1:0] word_idx(
        input logic [AW-1:0] a
    );
        word_idx = a[IDX_W+1:2];
    endfunction

    // narrow field into a zero-padded bus word
    function automatic logic [DATA_W-1:0] pad_evt(
        input logic [EVT_W-1:0] v
    );
        pad_evt = {{(DATA_W-EVT_W){1'b0}}, v};
    endfunction

    // is this index one of ours
    function automatic logic is_mapped(
        input logic [IDX_W-1:0] i
    );
        case (i)
            IDX_VOLT_D, IDX_VOLT_Q, IDX_ALIGN,
            IDX_OL_SPD, IDX_OL_CUR, IDX_CL_SPD,
            IDX_FLUX, IDX_TORQUE, IDX_ISD,
            IDX_EVT_STS, IDX_EVT_MSK: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    // one wait state: access cycle, then ready
    // pready is a flop so the slave answers on the
    // second access edge and never combinationally
    assign access  = psel && penable && !pready;
    assign fire    = psel && penable && pready;
    assign wr_fire = fire && pwrite;

    // address checks
    assign idx     = word_idx(paddr);
    assign aligned = (paddr[1:0] == 2'b00);
    assign hit     = aligned && is_mapped(idx);

    // read mux over the held snapshot
    always_comb begin
        rd_val = RST_WORD;
        case (idx)
            IDX_VOLT_D: begin
                // volts = word / 2^27 * 60 / sqrt 3
                rd_val = shadow.applied_d_axis_voltage; // RL1
            end
            IDX_VOLT_Q: begin
                // same scaling as the d axis
                rd_val = shadow.applied_q_axis_voltage; // RL2
            end
            IDX_ALIGN: begin
                // amps = word / 2^27 * base / 8
                rd_val = shadow.align_current_reference; // RL3
            end
            IDX_OL_SPD: begin
                // hertz = word / 2^27 * max speed
                rd_val = shadow.open_loop_speed_reference; // RL4 RL5
            end
            IDX_OL_CUR: begin
                // open-loop torque current
                rd_val = shadow.open_loop_current_reference; // RL6
            end
            IDX_CL_SPD: begin
                // speed loop target in hertz
                rd_val = shadow.closed_loop_speed_reference; // RL7
            end
            IDX_FLUX: begin
                // flux loop target
                rd_val = shadow.flux_current_reference; // RL8
            end
            IDX_TORQUE: begin
                // torque loop target
                rd_val = shadow.torque_current_reference; // RL9
            end
            IDX_ISD: begin
                // code in low half, upper half zero
                rd_val = {{(DATA_W-ISD_W){1'b0}},
                          shadow.initial_speed_detect_state}; // RL10
            end
            IDX_EVT_STS: begin
                // sticky events
                rd_val = pad_evt(evt_status);
            end
            IDX_EVT_MSK: begin
                // interrupt enables
                rd_val = pad_evt(evt_mask);
            end
            default: begin
                // unmapped reads as zero
                rd_val = RST_WORD;
            end
        endcase
        // misaligned addresses never alias a register
        if (!aligned) begin
            rd_val = RST_WORD;
        end
    end

    // snapshot of the engine, taken on its load strobe
    // the whole set updates together, so software reading
    // several words between two loads sees one consistent set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // every word zero out of reset
            shadow <= '0; // RL11
        end else if (telem_load) begin
            // bus writes never reach here
            shadow <= telem; // RL11
        end
    end

    // the stored open-loop word is the handover speed;
    // it is taken as the engine delivers it, never altered
    // here, so software sees the exact switch point

    // ready flop: high for exactly one cycle per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    // read data latched with ready, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RST_WORD;
        end else if (access && !pwrite) begin
            // data stands during the ready cycle only
            prdata <= rd_val;
        end else begin
            prdata <= RST_WORD;
        end
    end

    // error on unmapped or misaligned access
    // writes to telemetry words are not errors,
    // they simply leave the values untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !hit;
        end
    end

    // mask write honours the low byte lane only
    always_comb begin
        next_mask = evt_mask;
        if (wr_fire && aligned && idx == IDX_EVT_MSK
            && pstrb[0]) begin
            next_mask = pwdata[EVT_W-1:0];
        end
    end

    // mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask <= RST_EVT;
        end else begin
            evt_mask <= next_mask;
        end
    end

    // write-one-to-clear pulse for the status bits
    always_comb begin
        evt_clr = RST_EVT;
        if (wr_fire && aligned && idx == IDX_EVT_STS
            && pstrb[0]) begin
            evt_clr = pwdata[EVT_W-1:0];
        end
    end

    // event detection and sticky status
    ftrb_evt u_evt (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (telem_load),
        .old_code (shadow.initial_speed_detect_state),
        .new_code (telem.initial_speed_detect_state),
        .clr      (evt_clr),
        .status   (evt_status)
    );

    // interrupt level, registered so it leaves from a flop
    // lags the status bit by one cycle; harmless for a level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status & evt_mask);
        end
    end

endmodule

// File: tb/ftrb_bank_chk.sv
// checker for the telemetry bank: apb timing and snapshot read-back
// assumes it is bound onto ftrb_bank and everything runs on pclk
`timescale 1ns/1ps
module ftrb_bank_chk
    import ftrb_pkg::*;
#(
    parameter int AW = ADDR_W  // byte address width
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [AW-1:0]     paddr,
    input wire ftrb_telem_s       telem,
    input wire logic              telem_load,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    logic [DATA_W-1:0] sh_volt_d; // last loaded d voltage
    logic [DATA_W-1:0] sh_volt_q; // last loaded q voltage
    logic [ISD_W-1:0]  sh_isd;  // last loaded state code
    logic              rd;      // read answer this cycle

    assign rd = pready && !pwrite;

    // shadow of the snapshot; compared one cycle late, since read
    // data is registered from the value held in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_volt_d <= '0;
            sh_volt_q <= '0;
            sh_isd <= '0;
        end else if (telem_load) begin
            sh_volt_d <= telem.applied_d_axis_voltage;
            sh_volt_q <= telem.applied_q_axis_voltage;
            sh_isd <= telem.initial_speed_detect_state;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;  psel && !penable; endsequence
    sequence s_access; psel && penable;  endsequence

    property p_wait; s_setup ##1 s_access |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("late answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_nosel; !psel |=> !pready; endproperty
    a_nosel: assert property (p_nosel) else $error("stray ready");
    property p_idle; !pready |-> prdata == '0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("idle data");
    property p_volt_d;
        rd && paddr == {IDX_VOLT_D, 2'b00} |-> prdata == $past(sh_volt_d);
    endproperty
    a_volt_d: assert property (p_volt_d) else $error("d voltage wrong");
    property p_volt_q;
        rd && paddr == {IDX_VOLT_Q, 2'b00} |-> prdata == $past(sh_volt_q);
    endproperty
    a_volt_q: assert property (p_volt_q) else $error("q voltage wrong");
    property p_isd;
        rd && paddr == {IDX_ISD, 2'b00}
            |-> prdata == {16'h0000, $past(sh_isd)};
    endproperty
    a_isd: assert property (p_isd) else $error("state code wrong");
    property p_wr;
        pready && pwrite && paddr == {IDX_VOLT_D, 2'b00} |-> !pslverr;
    endproperty
    a_wr: assert property (p_wr) else $error("write refused");
    property p_mis;
        pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == '0;
    endproperty
    a_mis: assert property (p_mis) else $error("misaligned ok");
endmodule

bind ftrb_bank ftrb_bank_chk #(.AW(AW)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .telem(telem),
    .telem_load(telem_load), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
);

// File: tb/ftrb_bank_tb.sv
// self-checking bench for the telemetry register bank
// assumes the bank answers apb with pready and latches on telem_load
`timescale 1ns/1ps
module ftrb_bank_tb
    import ftrb_pkg::*;
();
    logic              pclk, presetn, psel, penable, pwrite, telem_load;
    logic [ADDR_W-1:0] paddr;             // byte address
    logic [DATA_W-1:0] pwdata, prdata, rd; // rd: last read data
    logic [STRB_W-1:0] pstrb;             // all lanes on
    logic              pready, pslverr, irq, er;
    ftrb_telem_s       tl;                // snapshot driven in
    int                bad_count, num_checks, cyc;
    logic [IDX_W-1:0]  idx [9];           // telemetry indexes in order
    logic [DATA_W-1:0] val [9];           // values to load

    ftrb_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .telem(tl),
        .telem_load(telem_load), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));

    // clock, and a cycle ceiling so a hang still ends in a verdict
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] ex(input int i);
        return (i == 8) ? {16'h0000, val[8][15:0]} : val[i];
    endfunction

    task automatic load();
        tl <= '{val[0], val[1], val[2], val[3], val[4], val[5], val[6],
                val[7], val[8][ISD_W-1:0]};
        telem_load <= 1;
        @(posedge pclk);
        telem_load <= 0;
        @(posedge pclk);
    endtask

    task automatic t_snap();
        for (int i = 0; i < 9; i++) begin
            apb(0, {idx[i], 2'b00}, 0);
            chk(rd, ex(i), "read back");
            chk(er, 0, "error flag");
        end
        $display("t_snap done");
    endtask

    task automatic t_ro();
        for (int i = 0; i < 9; i++) begin
            apb(1, {idx[i], 2'b00}, ~val[i]);
            chk(er, 0, "write error");
            apb(0, {idx[i], 2'b00}, 0);
            chk(rd, ex(i), "value after write");
        end
        $display("t_ro done");
    endtask

    task automatic t_isd();
        for (int c = 0; c < 5; c++) begin
            val[8] = c;
            load();
            apb(0, {IDX_ISD, 2'b00}, 0);
            chk(rd, c, "state code");
        end
        $display("t_isd done");
    endtask

    task automatic t_err();
        apb(0, 14'h0004, 0);
        chk(er, 1, "unmapped read error");
        chk(rd, 0, "unmapped read data");
        apb(1, {IDX_VOLT_D, 2'b01}, 32'h1);
        chk(er, 1, "misaligned write");
        $display("t_err done");
    endtask

    task automatic t_irq();
        apb(1, {IDX_EVT_STS, 2'b00}, 32'hf);
        val[8] = speed_detect_done;
        load();
        apb(0, {IDX_EVT_STS, 2'b00}, 0);
        chk(rd, 32'h7, "status after done");
        chk(irq, 0, "masked irq");
        apb(1, {IDX_EVT_MSK, 2'b00}, 32'h4);
        // irq leaves its flop one edge after the mask lands
        @(posedge pclk);
        chk(irq, 1, "irq raised");
        apb(1, {IDX_EVT_STS, 2'b00}, 32'h4);
        @(posedge pclk);
        chk(irq, 0, "irq cleared");
        apb(0, {IDX_EVT_STS, 2'b00}, 0);
        chk(rd, 32'h3, "status after clear");
        $display("t_irq done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // reset, then the scenarios in order
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; pstrb = 4'hf; telem_load = 0; tl = '0;
        idx = '{IDX_VOLT_D, IDX_VOLT_Q, IDX_ALIGN, IDX_OL_SPD, IDX_OL_CUR,
                IDX_CL_SPD, IDX_FLUX, IDX_TORQUE, IDX_ISD};
        foreach (val[i]) val[i] = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_snap();
        foreach (val[i]) val[i] = 32'h8765_4321 ^ (32'h0111_1111 * i);
        load();
        t_snap();
        t_ro();
        t_isd();
        t_err();
        t_irq();
        print_verdict();
    end
endmodule
